// ---- verilog/audio_codec_clock_tree.sv ----
// Audio codec clock tree: system clock, rate decoder, derived ticks
`timescale 1ns/1ps
`default_nettype none
`include "clock_tree_defs.svh"
module audio_codec_clock_tree (
  input  wire logic                         pclk,
  input  wire logic                         presetn,
  input  wire clock_tree_pkg::apb_req_t     apb_req,
  output var  clock_tree_pkg::apb_rsp_t     apb_rsp,
  input  wire logic                         master_clk_in,
  input  wire logic                         bit_clk_in,
  input  wire logic                         frame_clk_in,
  input  wire logic                         fll_out_tick,
  output var  clock_tree_pkg::ticks_t       ticks,
  output var  clock_tree_pkg::dividers_t    dividers,
  output var  logic                         bclk_out_en,
  output var  logic                         lrclk_out_en
);
  import clock_tree_pkg::*;
  // ==========================================================
  // Decode tables
  function automatic logic [10:0] ratio_val(input logic [3:0] code);
    case (code)
      4'h0:    ratio_val = 11'd64;
      4'h1:    ratio_val = 11'd128;
      4'h2:    ratio_val = 11'd192;
      4'h3:    ratio_val = 11'd256;
      4'h4:    ratio_val = 11'd384;
      4'h5:    ratio_val = 11'd512;
      4'h6:    ratio_val = 11'd768;
      4'h7:    ratio_val = 11'd1024;
      4'h8:    ratio_val = 11'd1408;
      4'h9:    ratio_val = 11'd1536;
      default: ratio_val = 11'd0;
    endcase
  endfunction : ratio_val
  // Nominal 48 kHz family; the 44.1 kHz family shares each code
  function automatic logic [5:0] fs_khz(input logic [2:0] code);
    case (code)
      3'h0:    fs_khz = 6'd8;
      3'h1:    fs_khz = 6'd12;
      3'h2:    fs_khz = 6'd16;
      3'h3:    fs_khz = 6'd24;
      3'h4:    fs_khz = 6'd32;
      3'h5:    fs_khz = 6'd48;
      default: fs_khz = 6'd0;
    endcase
  endfunction : fs_khz
  // Twice the divisor, so the half steps stay integral
  function automatic logic [6:0] bclk_d2(input logic [4:0] code);
    case (code)
      5'h00:   bclk_d2 = 7'd2;
      5'h01:   bclk_d2 = 7'd3;
      5'h02:   bclk_d2 = 7'd4;
      5'h03:   bclk_d2 = 7'd6;
      5'h04:   bclk_d2 = 7'd8;
      5'h05:   bclk_d2 = 7'd10;
      5'h06:   bclk_d2 = 7'd11;
      5'h07:   bclk_d2 = 7'd12;
      5'h08:   bclk_d2 = 7'd16;
      5'h09:   bclk_d2 = 7'd20;
      5'h0a:   bclk_d2 = 7'd22;
      5'h0b:   bclk_d2 = 7'd24;
      5'h0c:   bclk_d2 = 7'd32;
      5'h0d:   bclk_d2 = 7'd40;
      5'h0e:   bclk_d2 = 7'd44;
      5'h0f:   bclk_d2 = 7'd48;
      5'h10:   bclk_d2 = 7'd50;
      5'h11:   bclk_d2 = 7'd60;
      5'h12:   bclk_d2 = 7'd64;
      5'h13:   bclk_d2 = 7'd88;
      5'h14:   bclk_d2 = 7'd96;
      default: bclk_d2 = 7'd0;
    endcase
  endfunction : bclk_d2
  function automatic logic [6:0] gpio_output_clock_d2(input logic [3:0] code);
    case (code)
      4'h0:    gpio_output_clock_d2 = 7'd2;
      4'h1:    gpio_output_clock_d2 = 7'd4;
      4'h2:    gpio_output_clock_d2 = 7'd6;
      4'h3:    gpio_output_clock_d2 = 7'd8;
      4'h4:    gpio_output_clock_d2 = 7'd11;
      4'h5:    gpio_output_clock_d2 = 7'd12;
      4'h6:    gpio_output_clock_d2 = 7'd16;
      4'h7:    gpio_output_clock_d2 = 7'd24;
      4'h8:    gpio_output_clock_d2 = 7'd32;
      default: gpio_output_clock_d2 = 7'd0;
    endcase
  endfunction : gpio_output_clock_d2
  // Fractional divider step: {hit, new accumulator}; zero stops it
  function automatic logic [17:0] acc_step(input logic [16:0] acc,
                                           input logic [16:0] step,
                                           input logic [16:0] thr);
    logic [17:0] sum;
    sum = {1'b0, acc} + {1'b0, step};
    if (thr == 17'h0) begin
      acc_step = {1'b0, acc};
    end else if (sum >= {1'b0, thr}) begin
      acc_step = {1'b1, 17'(sum - {1'b0, thr})};
    end else begin
      acc_step = {1'b0, sum[16:0]};
    end
  endfunction : acc_step
  function automatic logic [4:0] shr_min1(input logic [10:0] v,
                                          input logic [3:0]  sh);
    logic [10:0] q;
    q = v >> sh;
    shr_min1 = (q == 11'h0) ? 5'h1 : q[4:0];
  endfunction : shr_min1
  function automatic logic [15:0] merge(input logic [15:0] old,
                                        input logic [31:0] data,
                                        input logic [3:0]  strb,
                                        input logic [15:0] mask);
    logic [15:0] lanes;
    lanes = {{8{strb[1]}}, {8{strb[0]}}};
    merge = ((old & ~lanes) | (data[15:0] & lanes)) & mask;
  endfunction : merge
  // ==========================================================
  // State
  state_t       s_r;
  state_t       s_nxt;
  logic [5:0]   idx;
  logic         mapped;
  logic         blocked;
  logic [31:0]  rd_val;
  logic         mclk_present;
  logic         mclk_rise;
  logic         bclk_rise;
  logic         lrclk_rise;
  logic         src_tick;
  logic         sys_tick;
  logic         dsp_tick;
  logic [10:0]  ratio;
  logic [17:0]  st_256;
  logic [17:0]  st_op;
  logic [17:0]  st_bclk;
  logic         lr_src;
  logic [10:0]  lr_rate;
  logic [2:0]   slow_sh;
  logic [15:0]  slow_per;
  assign apb_rsp      = s_r.rsp;
  assign ticks        = s_r.ticks;
  assign dividers     = s_r.divs;
  assign bclk_out_en  = s_r.bclk_oe;
  assign lrclk_out_en = s_r.lrclk_oe;
  // ==========================================================
  // Next state
  always_comb begin
    s_nxt    = s_r;
    idx      = apb_req.paddr[7:2];
    mapped   = 1'b1;
    rd_val   = 32'h0;
    // Pins pass three flops; edges are taken from the second and third
    s_nxt.mclk_sy  = {s_r.mclk_sy[1:0], master_clk_in};
    s_nxt.bclk_sy  = {s_r.bclk_sy[1:0], bit_clk_in};
    s_nxt.lrclk_sy = {s_r.lrclk_sy[1:0], frame_clk_in};
    // Inverting picks the falling edge instead
    mclk_rise  = (s_r.mclk_sy[1] ^ s_r.r_gate[`B_INVERT]) &
                 ~(s_r.mclk_sy[2] ^ s_r.r_gate[`B_INVERT]);
    bclk_rise  = s_r.bclk_sy[1] & ~s_r.bclk_sy[2];
    lrclk_rise = s_r.lrclk_sy[1] & ~s_r.lrclk_sy[2];
    // Presence: any master clock edge within the loss window
    if (s_r.mclk_sy[1] != s_r.mclk_sy[2]) begin
      s_nxt.loss_cnt = 6'h0;
    end else if (s_r.loss_cnt != 6'(`MCLK_LOSS_CYC)) begin
      s_nxt.loss_cnt = s_r.loss_cnt + 6'h1;
    end
    mclk_present = (s_r.loss_cnt != 6'(`MCLK_LOSS_CYC));
    // System clock as an enable pulse
    src_tick = s_r.r_gate[`B_SRC] ? fll_out_tick : mclk_rise;
    if (src_tick) begin
      s_nxt.half = ~s_r.half;
    end
    sys_tick = s_r.r_gate[`B_SYS_GATE] & src_tick &
               (~s_r.r_div_slow[`B_MASTER_DIV2] | s_r.half);
    dsp_tick = sys_tick & s_r.r_gate[`B_DSP_ON];
    s_nxt.ticks.sys = sys_tick;
    s_nxt.ticks.dsp = dsp_tick;
    // Rate decoder drives every converter divider
    ratio = ratio_val(s_r.r_rate_ratio[`F_RATIO]);
    s_nxt.divs.servo_div = ratio;
    s_nxt.divs.adc_div   = shr_min1(ratio, 4'd7);
    s_nxt.divs.dsp_div   = shr_min1(ratio, 4'd8);
    s_nxt.divs.dac_div   = shr_min1(ratio,
                             s_r.r_dac_cfg[`B_DAC_DOUBLE] ? 4'd7 : 4'd6);
    // One frame tick feeds both converter paths
    s_nxt.ticks.fs = 1'b0;
    if (dsp_tick && ratio != 11'h0) begin
      if (s_r.fs_cnt >= ratio - 11'h1) begin
        s_nxt.fs_cnt   = 11'h0;
        s_nxt.ticks.fs = 1'b1;
      end else begin
        s_nxt.fs_cnt = s_r.fs_cnt + 11'h1;
      end
    end

    // Reserved rate codes give zero and stop the tick
    st_256 = acc_step(s_r.acc_256, `TICK256_KHZ,
                      17'(ratio) * 17'(fs_khz(s_r.r_rate_ratio[`F_RATE])));
    s_nxt.ticks.t256 = sys_tick & st_256[17];
    if (sys_tick) begin
      s_nxt.acc_256 = st_256[16:0];
    end

    // GPIO clock; reserved codes hold it still
    st_op = acc_step(s_r.acc_op, 17'd2,
                     17'(gpio_output_clock_d2(s_r.r_bclk_div[`F_GPIO_OUTPUT_CLOCK_DIVIDER])));
    s_nxt.ticks.gpio_output_clock = 1'b0;
    if (sys_tick && s_r.r_gate[`B_GPIO_OUTPUT_CLOCK_ON]) begin
      s_nxt.acc_op      = st_op[16:0];
      s_nxt.ticks.gpio_output_clock = st_op[17];
    end

    // Master bit clock, fractional steps averaged
    st_bclk = acc_step(s_r.acc_bclk, 17'd2,
                       17'(bclk_d2(s_r.r_bclk_div[`F_BCLK_DIV])));
    s_nxt.ticks.bclk = 1'b0;
    if (sys_tick && s_r.r_bclk_dir[`B_BCLK_DIR]) begin
      s_nxt.acc_bclk   = st_bclk[16:0];
      s_nxt.ticks.bclk = st_bclk[17];
    end
    s_nxt.bclk_oe  = s_r.r_bclk_dir[`B_BCLK_DIR];
    s_nxt.lrclk_oe = s_r.r_lrclk[`B_LRCLK_DIR];

    // Frame clock from internal or external bit clock
    lr_src  = s_r.r_bclk_dir[`B_BCLK_DIR] ?
              (sys_tick & st_bclk[17]) : bclk_rise;
    lr_rate = s_r.r_lrclk[`F_LRCLK_RATE];
    s_nxt.ticks.lrclk = 1'b0;
    if (lr_src && s_r.r_lrclk[`B_LRCLK_DIR] &&
        lr_rate >= `LRCLK_MIN_RATE) begin
      if (s_r.lr_cnt >= lr_rate - 11'h1) begin
        s_nxt.lr_cnt      = 11'h0;
        s_nxt.ticks.lrclk = 1'b1;
      end else begin
        s_nxt.lr_cnt = s_r.lr_cnt + 11'h1;
      end
    end

    // Slow clock: 256 ticks at the fastest, doubling per step
    slow_sh  = {s_r.r_div_slow[`B_SLOW_DIV16],
                ~s_r.r_div_slow[`B_SLOW_X4],
                ~s_r.r_gate[`B_SLOW_HALF]};
    slow_per = `SLOW_BASE_TICKS << slow_sh;
    s_nxt.ticks.slow = 1'b0;
    if (s_r.ticks.t256 && s_r.r_gate[`B_SLOW_ON]) begin
      if (s_r.slow_cnt >= slow_per - 16'h1) begin
        s_nxt.slow_cnt   = 16'h0;
        s_nxt.ticks.slow = 1'b1;
      end else begin
        s_nxt.slow_cnt = s_r.slow_cnt + 16'h1;
      end
    end

    // Loop reference selection
    s_nxt.ticks.fll_free = 1'b0;
    case (fll_ref_t'(s_r.r_fll_ref[`F_FLL_REF]))
      REF_MASTER: s_nxt.ticks.fll_ref = mclk_rise;
      REF_BIT:    s_nxt.ticks.fll_ref = bclk_rise;
      REF_FRAME:  s_nxt.ticks.fll_ref = lrclk_rise;
      default: begin
        s_nxt.ticks.fll_ref  = 1'b0;
        s_nxt.ticks.fll_free = 1'b1;
      end
    endcase
    // ========================================================
    // APB slave, one wait state
    case (idx)
      `IDX_DIV_SLOW:   rd_val = {16'h0, s_r.r_div_slow};
      `IDX_RATE_RATIO: rd_val = {16'h0, s_r.r_rate_ratio};
      `IDX_GATE:       rd_val = {16'h0, s_r.r_gate};
      `IDX_BCLK_DIR:   rd_val = {16'h0, s_r.r_bclk_dir};
      `IDX_BCLK_DIV:   rd_val = {16'h0, s_r.r_bclk_div};
      `IDX_LRCLK:      rd_val = {16'h0, s_r.r_lrclk};
      `IDX_DAC_CFG:    rd_val = {16'h0, s_r.r_dac_cfg};
      `IDX_FLL_REF:    rd_val = {16'h0, s_r.r_fll_ref};
      `IDX_STATUS:     rd_val = {4'h0, s_r.divs.servo_div,
                                 s_r.divs.dsp_div, s_r.divs.adc_div,
                                 s_r.divs.dac_div,
                                 (s_r.r_rate_ratio[`F_RATE] > 3'h5),
                                 mclk_present};
      default:         mapped = 1'b0;
    endcase
    // Gate register stays reachable with no master clock
    blocked = s_r.r_gate[`B_SYS_GATE] & ~mclk_present &
              (idx != `IDX_GATE);
    if (apb_req.psel && apb_req.penable && !s_r.rsp.pready) begin
      s_nxt.rsp.pready  = 1'b1;
      s_nxt.rsp.pslverr = ~mapped | blocked |
                          (apb_req.pwrite & (idx == `IDX_STATUS));
      s_nxt.rsp.prdata  = (apb_req.pwrite | ~mapped | blocked) ?
                          32'h0 : rd_val;
    end else begin
      s_nxt.rsp.pready  = 1'b0;
      s_nxt.rsp.pslverr = 1'b0;
    end
    // Write lands on the completing edge, only if not refused
    if (apb_req.psel && apb_req.penable && s_r.rsp.pready &&
        apb_req.pwrite && !s_r.rsp.pslverr) begin
      case (idx)
        `IDX_DIV_SLOW:   s_nxt.r_div_slow = merge(s_r.r_div_slow,
                           apb_req.pwdata, apb_req.pstrb, `MSK_DIV_SLOW);
        `IDX_RATE_RATIO: s_nxt.r_rate_ratio = merge(s_r.r_rate_ratio,
                           apb_req.pwdata, apb_req.pstrb, `MSK_RATE_RATIO);
        `IDX_GATE:       s_nxt.r_gate = merge(s_r.r_gate,
                           apb_req.pwdata, apb_req.pstrb, `MSK_GATE);
        `IDX_BCLK_DIR:   s_nxt.r_bclk_dir = merge(s_r.r_bclk_dir,
                           apb_req.pwdata, apb_req.pstrb, `MSK_BCLK_DIR);
        `IDX_BCLK_DIV:   s_nxt.r_bclk_div = merge(s_r.r_bclk_div,
                           apb_req.pwdata, apb_req.pstrb, `MSK_BCLK_DIV);
        `IDX_LRCLK:      s_nxt.r_lrclk = merge(s_r.r_lrclk,
                           apb_req.pwdata, apb_req.pstrb, `MSK_LRCLK);
        `IDX_DAC_CFG:    s_nxt.r_dac_cfg = merge(s_r.r_dac_cfg,
                           apb_req.pwdata, apb_req.pstrb, `MSK_DAC_CFG);
        `IDX_FLL_REF:    s_nxt.r_fll_ref = merge(s_r.r_fll_ref,
                           apb_req.pwdata, apb_req.pstrb, `MSK_FLL_REF);
        default:         s_nxt.r_fll_ref = s_r.r_fll_ref;
      endcase
    end
  end
  // ==========================================================
  // State register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_r              <= '0;
      s_r.loss_cnt     <= 6'(`MCLK_LOSS_CYC);  // Absent until an edge
      s_r.r_rate_ratio <= `RST_RATE_RATIO;
      s_r.r_bclk_div   <= `RST_BCLK_DIV;
      s_r.r_lrclk      <= `RST_LRCLK;
    end else begin
      s_r <= s_nxt;
    end
  end
endmodule : audio_codec_clock_tree

`default_nettype wire

// ---- verilog/clock_tree_defs.svh ----
// Register indices, field positions, reset values and timing counts
`ifndef CLOCK_TREE_DEFS_SVH
`define CLOCK_TREE_DEFS_SVH
// ==========================================================
// Register indices (byte address is four times the index)
`define IDX_DIV_SLOW    6'h14
`define IDX_RATE_RATIO  6'h15
`define IDX_GATE        6'h16
`define IDX_BCLK_DIR    6'h19
`define IDX_BCLK_DIV    6'h1a
`define IDX_LRCLK       6'h1b
`define IDX_DAC_CFG     6'h21
`define IDX_FLL_REF     6'h3e
`define IDX_STATUS      6'h3f
// ==========================================================
// Field positions
`define B_MASTER_DIV2   0
`define B_SLOW_X4       13
`define B_SLOW_DIV16    14
`define F_RATIO         13:10
`define F_RATE          2:0
`define B_INVERT        15
`define B_SRC           14
`define B_SLOW_HALF     12
`define B_GPIO_OUTPUT_CLOCK_ON      3
`define B_SYS_GATE      2
`define B_DSP_ON        1
`define B_SLOW_ON       0
`define B_BCLK_DIR      6
`define F_BCLK_DIV      4:0
`define F_GPIO_OUTPUT_CLOCK_DIVIDER     11:8
`define B_LRCLK_DIR     11
`define F_LRCLK_RATE    10:0
`define B_DAC_DOUBLE    6
`define F_FLL_REF       1:0
// ==========================================================
// Reset values and implemented-bit masks
`define RST_RATE_RATIO  16'h0c05
`define RST_BCLK_DIV    16'h0004
`define RST_LRCLK       16'h0040
`define MSK_DIV_SLOW    16'h6001
`define MSK_RATE_RATIO  16'h3c07
`define MSK_GATE        16'hd00f
`define MSK_BCLK_DIR    16'h0040
`define MSK_BCLK_DIV    16'h0f1f
`define MSK_LRCLK       16'h0fff
`define MSK_DAC_CFG     16'h0040
`define MSK_FLL_REF     16'h0003
// ==========================================================
// Timing
`define CLK_PERIOD_PS   25000
`define MCLK_LOSS_NS    1000
`define MCLK_LOSS_CYC   (`MCLK_LOSS_NS * 1000 / `CLK_PERIOD_PS)
`define TICK256_KHZ     17'd256
`define LRCLK_MIN_RATE  11'd8
`define SLOW_BASE_TICKS 16'd256
`endif

// ---- verilog/clock_tree_pkg.sv ----
// Types shared by the clock tree and its bench
package clock_tree_pkg;
  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
    logic [3:0]  pstrb;
  } apb_req_t;
  typedef struct packed {
    logic        pready;
    logic        pslverr;
    logic [31:0] prdata;
  } apb_rsp_t;
  typedef enum logic [1:0] {
    REF_MASTER = 2'b00,
    REF_BIT    = 2'b01,
    REF_FRAME  = 2'b10,
    REF_FREE   = 2'b11
  } fll_ref_t;
  typedef struct packed {
    logic sys;
    logic dsp;
    logic fs;
    logic bclk;
    logic lrclk;
    logic gpio_output_clock;
    logic t256;
    logic slow;
    logic fll_ref;
    logic fll_free;
  } ticks_t;
  typedef struct packed {
    logic [4:0]  adc_div;
    logic [4:0]  dac_div;
    logic [4:0]  dsp_div;
    logic [10:0] servo_div;
  } dividers_t;
  typedef struct packed {
    logic [15:0] r_div_slow;
    logic [15:0] r_rate_ratio;
    logic [15:0] r_gate;
    logic [15:0] r_bclk_dir;
    logic [15:0] r_bclk_div;
    logic [15:0] r_lrclk;
    logic [15:0] r_dac_cfg;
    logic [15:0] r_fll_ref;
    logic [2:0]  mclk_sy;
    logic [2:0]  bclk_sy;
    logic [2:0]  lrclk_sy;
    logic [5:0]  loss_cnt;
    logic        half;
    logic [10:0] fs_cnt;
    logic [16:0] acc_256;
    logic [16:0] acc_op;
    logic [16:0] acc_bclk;
    logic [10:0] lr_cnt;
    logic [15:0] slow_cnt;
    ticks_t      ticks;
    dividers_t   divs;
    logic        bclk_oe;
    logic        lrclk_oe;
    apb_rsp_t    rsp;
  } state_t;
endpackage : clock_tree_pkg

// ---- test/clock_tree_props.sv ----
// Port-level checks for the audio codec clock tree
`timescale 1ns/1ps
`default_nettype none
module clock_tree_props (
  input wire logic                      pclk,
  input wire logic                      presetn,
  input wire clock_tree_pkg::apb_req_t  apb_req,
  input wire clock_tree_pkg::apb_rsp_t  apb_rsp,
  input wire logic                      master_clk_in,
  input wire logic                      fll_out_tick,
  input wire clock_tree_pkg::ticks_t    ticks
);
  import clock_tree_pkg::*;
  // ==========================================================
  // Shadow of the clock setup as seen from accepted writes
  logic [15:0] gate_r;
  logic [15:0] div_r;
  logic [5:0]  quiet_r;
  logic [3:0]  age_r;
  logic        mprev_r;
  wire logic [5:0] idx = apb_req.paddr[7:2];
  wire logic wr_ok = apb_rsp.pready & apb_req.pwrite & ~apb_rsp.pslverr;
  // Pin quiet longer than the loss window plus synchroniser delay
  wire logic lost = quiet_r == 6'h3f;
  wire logic steady = age_r == 4'hf && gate_r[2] && !div_r[0];
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      gate_r <= '0;
      div_r <= '0;
      quiet_r <= '0;
      age_r <= '0;
      mprev_r <= 1'b0;
    end else begin
      mprev_r <= master_clk_in;
      quiet_r <= (master_clk_in != mprev_r) ? 6'h0
               : quiet_r + {5'h0, quiet_r != 6'h3f};
      age_r <= age_r + {3'h0, age_r != 4'hf};
      if (wr_ok && (idx == 6'h16 || idx == 6'h14)) age_r <= 4'h0;
      if (wr_ok && idx == 6'h16) gate_r <= apb_req.pwdata[15:0];
      if (wr_ok && idx == 6'h14) div_r <= apb_req.pwdata[15:0];
    end
  end
  // ==========================================================
  // Assertions
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_ready_pulse: assert property (apb_rsp.pready |=> !apb_rsp.pready)
    else $error("pready held two cycles");
  a_ready_wait: assert property (apb_req.psel && apb_req.penable &&
    !apb_rsp.pready |=> apb_rsp.pready) else $error("no pready");
  a_ready_idle: assert property (!(apb_req.psel && apb_req.penable)
    |=> !apb_rsp.pready) else $error("pready without access");
  a_gate_reg: assert property (apb_rsp.pready && idx == 6'h16 |->
    !apb_rsp.pslverr) else $error("gate register refused");
  a_open_ungated: assert property (apb_rsp.pready && !gate_r[2] &&
    idx == 6'h15 |-> !apb_rsp.pslverr) else $error("refused ungated");
  a_lost_refuse: assert property (apb_rsp.pready && gate_r[2] && lost &&
    idx != 6'h16 |-> apb_rsp.pslverr) else $error("access without clock");
  a_err_zero: assert property (apb_rsp.pslverr |-> apb_rsp.prdata == 32'h0)
    else $error("data on error");
  a_gate_off: assert property (age_r == 4'hf && !gate_r[2] |-> !ticks.sys)
    else $error("system tick while gated");
  a_dsp_off: assert property (age_r == 4'hf && !gate_r[1] |-> !ticks.dsp)
    else $error("core tick while off");
  a_master_edge: assert property (steady && !gate_r[14] && (gate_r[15] ?
    $fell(master_clk_in) : $rose(master_clk_in)) |-> ##[3:5]
    (ticks.sys || age_r != 4'hf)) else $error("master edge lost");
  a_loop_edge: assert property (steady && gate_r[14] && fll_out_tick |->
    ##[1:3] (ticks.sys || age_r != 4'hf)) else $error("loop edge lost");
endmodule : clock_tree_props
bind audio_codec_clock_tree clock_tree_props i_clock_tree_props (
  .pclk, .presetn, .apb_req, .apb_rsp, .master_clk_in, .fll_out_tick, .ticks);
`default_nettype wire

// ---- test/master_clock_src.sv ----
// External master clock source, free phase against the bus clock
`timescale 1ns/1ps
`default_nettype none
module master_clock_src #(
  parameter int HALF_NS = 61
) (
  input  wire logic run,
  output var  logic mclk
);
  initial begin
    mclk = 1'b0;
    forever begin
      #(HALF_NS);
      // About 8.2 MHz keeps the system clock above its floor
      // Stopped source rests low as a pulled-down pin would
      mclk = run ? ~mclk : 1'b0;
    end
  end
endmodule : master_clock_src
`default_nettype wire

// ---- test/audio_codec_clock_tree_tb.sv ----
// Self-checking bench for the audio codec clock tree
`timescale 1ns/1ps
`default_nettype none
module audio_codec_clock_tree_tb;
  import clock_tree_pkg::*;
  typedef struct packed {logic err; logic [31:0] data;} note_t;
  logic      pclk, presetn, run, fll_on, fll_tick, mclk, dbl, boe, loe;
  apb_req_t  req;
  apb_rsp_t  rsp;
  ticks_t    tk;
  dividers_t dv, dx;
  note_t     notes[$];
  int        err_total, samples_checked, r, q;
  int        cnt[9], base[9], d[9];
  int        ratio_tab[10] = '{64,128,192,256,384,512,768,1024,1408,1536};
  int        op2_tab[9] = '{2,4,6,8,11,12,16,24,32};
  audio_codec_clock_tree i_audio_codec_clock_tree (
    .pclk, .presetn, .apb_req(req), .apb_rsp(rsp), .master_clk_in(mclk),
    .bit_clk_in(mclk), .frame_clk_in(mclk), .fll_out_tick(fll_tick),
    .ticks(tk), .dividers(dv), .bclk_out_en(boe), .lrclk_out_en(loe));
  master_clock_src i_master_clock_src (.run, .mclk);
  initial begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end
  // ==========================================================
  // Helpers
  task automatic check(input logic [32:0] seen, input logic [32:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      err_total++;
      $display("MISMATCH t=%0t seen %h exp %h", $time, seen, exp);
    end
  endtask : check
  function automatic logic [32:0] near(input int a, b, t);
    return {32'h0, a >= b - t && a <= b + t};
  endfunction : near
  function automatic logic [4:0] mx(input int v);
    return (v < 1) ? 5'd1 : v[4:0];
  endfunction : mx
  task automatic apb(input logic wr, input logic [5:0] idx,
                     input logic [15:0] wd, input logic [31:0] rd,
                     input logic err);
    int n;
    notes.push_back({err, err ? 32'h0 : rd});
    req.psel <= 1'b1;
    req.pwrite <= wr;
    req.paddr <= {idx, 2'b00};
    req.pwdata <= {16'h0, wd};
    req.pstrb <= 4'hf;
    @(posedge pclk);
    req.penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (rsp.pready !== 1'b1 && n < 20);
    if (n == 20) check(33'h0, 33'h1);
    req.psel <= 1'b0;
    req.penable <= 1'b0;
    @(posedge pclk);
  endtask : apb
  task automatic meas(input int n);
    base = cnt;
    repeat (n) @(posedge pclk);
    foreach (d[i]) d[i] = cnt[i] - base[i];
  endtask : meas
  task automatic wait_slow();
    int n;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (tk.slow !== 1'b1 && n < 20000);
    if (n == 20000) check(33'h0, 33'h1);
  endtask : wait_slow
  task automatic give_verdict();
    $display("mismatches %0d checks %0d", err_total, samples_checked);
    if (err_total == 0 && samples_checked > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : give_verdict
  // ==========================================================
  // Response monitor, pulse counters and loop output
  always @(posedge pclk) begin
    if (rsp.pready === 1'b1) begin
      if (notes.size() == 0) check(33'h1, 33'h0);
      else check({rsp.pslverr, rsp.prdata}, notes.pop_front());
    end
    cnt[0] <= cnt[0] + int'(tk.sys === 1'b1);
    cnt[1] <= cnt[1] + int'(tk.gpio_output_clock === 1'b1);
    cnt[2] <= cnt[2] + int'(tk.t256 === 1'b1);
    cnt[3] <= cnt[3] + int'(fll_tick === 1'b1);
    cnt[5] <= cnt[5] + int'(tk.bclk === 1'b1);
    cnt[6] <= cnt[6] + int'(tk.lrclk === 1'b1);
    cnt[7] <= cnt[7] + int'(tk.fs === 1'b1);
    cnt[8] <= cnt[8] + int'(tk.fll_ref === 1'b1);
    fll_tick <= fll_on && !fll_tick && $urandom_range(1, 0) == 1;
  end
  always @(posedge mclk) cnt[4] <= cnt[4] + 1;
  initial begin
    repeat (60000) @(posedge pclk);
    err_total++;
    give_verdict();
  end
  // ==========================================================
  // Tests
  initial begin
    req = '0;
    presetn = 1'b0;
    run = 1'b0;
    fll_on = 1'b0;
    fll_tick = 1'b0;
    cnt = '{default: 0};
    void'($urandom(17));
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    repeat (2) @(posedge pclk);
    check({7'h0, dv}, {7'h0, 5'd2, 5'd4, 5'd1, 11'd256});
    apb(0, 6'h15, 0, 32'h0c05, 0);
    apb(0, 6'h16, 0, 32'h0, 0);
    apb(0, 6'h1a, 0, 32'h4, 0);
    apb(0, 6'h30, 0, 0, 1);
    apb(1, 6'h3f, 16'hffff, 0, 1);
    for (int c = 0; c < 10; c++) begin
      r = ratio_tab[c];
      q = c % 8;
      dbl = 1'($urandom_range(1, 0));
      apb(1, 6'h21, {9'h0, dbl, 6'h0}, 0, 0);
      apb(1, 6'h15, {2'h0, c[3:0], 7'h0, q[2:0]}, 0, 0);
      repeat (2) @(posedge pclk);
      dx = {mx(r >> 7), mx(r >> (6 + dbl)), mx(r >> 8), r[10:0]};
      check({7'h0, dv}, {7'h0, dx});
      apb(0, 6'h3f, 0, {4'h0, dx.servo_div, dx.dsp_div, dx.adc_div,
          dx.dac_div, q > 5, 1'b0}, 0);
    end
    // Clock present before the gate opens
    run <= 1'b1;
    apb(1, 6'h15, 16'h0c05, 0, 0);
    for (int m = 0; m < 3; m++) begin
      apb(1, 6'h16, 16'h0, 0, 0);
      apb(1, 6'h14, {15'h0, m == 2}, 0, 0);
      apb(1, 6'h16, {m == 1, 12'h0, 3'b110}, 0, 0);
      meas(800);
      check(near(d[0] * (1 + (m == 2)), d[4], 2), 33'h1);
    end
    apb(0, 6'h14, 0, 32'h1, 0);
    run <= 1'b0;
    repeat (80) @(posedge pclk);
    apb(1, 6'h15, 16'h0, 0, 1);
    apb(0, 6'h16, 0, 32'h6, 0);
    apb(1, 6'h16, 16'h0, 0, 0);
    apb(0, 6'h15, 0, 32'h0c05, 0);
    run <= 1'b1;
    apb(1, 6'h14, 16'h0, 0, 0);
    meas(400);
    check(near(d[0], 0, 0), 33'h1);
    fll_on <= 1'b1;
    apb(1, 6'h16, 16'h400e, 0, 0);
    for (int k = 0; k < 10; k++) begin
      apb(1, 6'h1a, {4'h0, k[3:0], 8'h04}, 0, 0);
      meas(1200);
      check(near(d[0], d[3], 2), 33'h1);
      check(near(d[2], d[0] / 48, 1), 33'h1);
      if (k < 9) check(near(d[1], 2 * d[0] / op2_tab[k], 1), 33'h1);
      else check(near(d[1], 0, 0), 33'h1);
    end
    apb(1, 6'h16, 16'h4006, 0, 0);
    meas(400);
    check(near(d[1], 0, 0), 33'h1);
    // Master bit and frame clocks, then the external bit clock
    apb(1, 6'h19, 16'h0040, 0, 0);
    apb(1, 6'h1b, 16'h0808, 0, 0);
    meas(1200);
    check({31'h0, boe, loe}, 33'h3);
    check(near(d[5], d[0] / 4, 1), 33'h1);
    check(near(d[6], d[5] / 8, 1), 33'h1);
    check(near(d[7], d[0] / 256, 1), 33'h1);
    apb(1, 6'h19, 16'h0, 0, 0);
    meas(1200);
    check({31'h0, boe, loe}, 33'h1);
    check(near(d[6], d[4] / 8, 1), 33'h1);
    apb(1, 6'h1b, 16'h0807, 0, 0);
    meas(400);
    check(near(d[6], 0, 0), 33'h1);
    for (int f = 0; f < 4; f++) begin
      apb(1, 6'h3e, 16'(f), 0, 0);
      meas(400);
      check(near(d[8], (f < 3) ? d[4] : 0, 1), 33'h1);
      check({32'h0, tk.fll_free}, {32'h0, f == 3});
    end
    // Fastest slow rate at ratio 64: one pulse per 3072 system ticks
    // Ratio 64 assumes mono mode, one DAC off
    apb(1, 6'h15, 16'h0005, 0, 0);
    apb(1, 6'h14, 16'h2000, 0, 0);
    apb(1, 6'h16, 16'h5007, 0, 0);
    wait_slow();
    base = cnt;
    wait_slow();
    check(near(cnt[0] - base[0], 3072, 12), 33'h1);
    give_verdict();
  end
endmodule : audio_codec_clock_tree_tb
`default_nettype wire
